// ### hdl/ckbsm_pkg.sv
// constants, register map and state codes of the clock buffer control bank
package ckbsm_pkg;
  localparam int NREG = 8;
  localparam logic [6:0] SLV_ADDR = 7'h6d;
  // register indices
  localparam logic [7:0] IDX_OE = 8'h00;
  localparam logic [7:0] IDX_PLL = 8'h01;
  localparam logic [7:0] IDX_SLEW = 8'h02;
  localparam logic [7:0] IDX_FREQ = 8'h03;
  localparam logic [7:0] IDX_RSVD = 8'h04;
  localparam logic [7:0] IDX_REV = 8'h05;
  localparam logic [7:0] IDX_DEV = 8'h06;
  localparam logic [7:0] IDX_CNT = 8'h07;
  // field positions
  localparam int OE1_BIT = 5;
  localparam int OE0_BIT = 3;
  localparam int PLL_SW_BIT = 5;
  localparam int PLL_LO = 3;
  localparam int PLL_RB_LO = 6;
  localparam int SLEW1_BIT = 5;
  localparam int SLEW0_BIT = 3;
  localparam int FSW_BIT = 5;
  localparam int FSEL_LO = 3;
  localparam int FB_SLEW_BIT = 0;
  // values after reset, reserved bits included
  localparam logic [7:0] RST_TAB [NREG] = '{
    8'h39, 8'h06, 8'ha9, 8'hc3, 8'hff, 8'h00, 8'h00, 8'h08};
  // bits that a write may change
  localparam logic [7:0] WMASK_TAB [NREG] = '{
    8'h28, 8'h3b, 8'h28, 8'h39, 8'h00, 8'h00, 8'h00, 8'h1f};
  localparam logic [7:0] RSVD_READ = 8'hff;
  localparam logic [1:0] FSEL_DEFAULT = 2'b00;
  localparam logic [1:0] LATCH_DELAY = 2'd3;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_ACK = 6'b000100,
    ST_RX = 6'b001000,
    ST_TX = 6'b010000,
    ST_TACK = 6'b100000
  } ckbsm_state_type;
endpackage : ckbsm_pkg

// ### hdl/ckbsm_regs.sv
// serial bus slave and control register bank of the two-output clock buffer
`timescale 1ns/100ps
module ckbsm_regs #(
  parameter logic [3:0] REV_ID = 4'h5, // arbitrary value
  parameter logic [3:0] VENDOR_ID = 4'ha, // arbitrary value
  parameter logic [1:0] DEV_TYPE = 2'h2, // arbitrary value
  parameter logic [5:0] DEV_ID = 6'h2a // arbitrary value
) (
  // clock and reset, the power-down input drives rst_n_i
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // mode and enable pins
  input wire logic oe0_n_i,
  input wire logic oe1_n_i,
  input wire logic [1:0] pll_mode_pin_i,
  // controls to the analog side
  output logic out0_run_o,
  output logic out1_run_o,
  output logic [1:0] pll_mode_o,
  output logic [1:0] amplitude_o,
  output logic out0_edge_rate_sel_o,
  output logic out1_edge_rate_sel_o,
  output logic feedback_edge_rate_sel_o,
  output logic freq_sw_en_o,
  output logic [1:0] input_freq_sel_o
);
  ckbsm_pkg::ckbsm_state_type state_ff;
  logic [2:0] scl_sy_ff;
  logic [2:0] sda_sy_ff;
  logic [1:0] oe0_sy_ff;
  logic [1:0] oe1_sy_ff;
  logic [1:0] pm_m_ff;
  logic [1:0] pm_s_ff;
  logic [1:0] lat_cnt_ff;
  logic [1:0] mode_lat_ff;
  logic [7:0] regs_ff [ckbsm_pkg::NREG];
  logic [3:0] bit_cnt_ff;
  logic [7:0] sh_ff;
  logic rw_ff;
  logic nack_ff;
  logic first_rd_ff;
  logic sda_oe_ff;
  logic [1:0] byte_no_ff;
  logic [7:0] ptr_ff;
  logic [7:0] wcnt_ff;
  logic wr_stb_ff;
  logic [7:0] wr_idx_ff;
  logic [7:0] wr_dat_ff;
  logic [7:0] rd_val;
  logic [7:0] tx_val;
  logic scl_s;
  logic scl_q;
  logic sda_s;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_done;
  logic rx_done;
  logic do_load;
  logic data_wr;

  // pins come from another domain: two flops first, third for edges
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sy_ff <= 3'h7;
      sda_sy_ff <= 3'h7;
      oe0_sy_ff <= 2'h3;
      oe1_sy_ff <= 2'h3;
      pm_m_ff <= 2'h0;
      pm_s_ff <= 2'h0;
    end else begin
      scl_sy_ff <= {scl_sy_ff[1:0], scl_i};
      sda_sy_ff <= {sda_sy_ff[1:0], sda_i};
      oe0_sy_ff <= {oe0_sy_ff[0], oe0_n_i};
      oe1_sy_ff <= {oe1_sy_ff[0], oe1_n_i};
      pm_m_ff <= pll_mode_pin_i;
      pm_s_ff <= pm_m_ff;
    end
  end

  assign scl_s = scl_sy_ff[1];
  assign scl_q = scl_sy_ff[2];
  assign sda_s = sda_sy_ff[1];
  assign sda_q = sda_sy_ff[2];
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;
  assign addr_done = (state_ff == ckbsm_pkg::ST_ADDR) && scl_fall && (bit_cnt_ff == 4'd8);
  assign rx_done = (state_ff == ckbsm_pkg::ST_RX) && scl_fall && (bit_cnt_ff == 4'd8);
  assign data_wr = rx_done && (byte_no_ff == 2'd2) && (wcnt_ff != 8'h00);
  assign do_load = scl_fall && (((state_ff == ckbsm_pkg::ST_ACK) && rw_ff)
                   || ((state_ff == ckbsm_pkg::ST_TACK) && !nack_ff));

  // mode pins settle through the synchroniser before they are caught once
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_cnt_ff <= 2'd0;
      mode_lat_ff <= 2'b00;
    end else if (lat_cnt_ff != ckbsm_pkg::LATCH_DELAY) begin
      lat_cnt_ff <= lat_cnt_ff + 2'd1;
      if (lat_cnt_ff == ckbsm_pkg::LATCH_DELAY - 2'd1) begin
        mode_lat_ff <= pm_s_ff;
      end
    end
  end

  // register storage; masked write keeps reserved bits at default
  for (genvar g = 0; g < ckbsm_pkg::NREG; g++) begin : g_reg
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        regs_ff[g] <= ckbsm_pkg::RST_TAB[g];
      end else if (wr_stb_ff && (wr_idx_ff == 8'(g))) begin
        regs_ff[g] <= (regs_ff[g] & ~ckbsm_pkg::WMASK_TAB[g])
                      | (wr_dat_ff & ckbsm_pkg::WMASK_TAB[g]);
      end
    end
  end

  // read view of the map; unmapped indices read zero
  always_comb begin
    case (ptr_ff)
      ckbsm_pkg::IDX_OE, ckbsm_pkg::IDX_SLEW,
      ckbsm_pkg::IDX_FREQ, ckbsm_pkg::IDX_CNT: rd_val = regs_ff[ptr_ff[2:0]];
      ckbsm_pkg::IDX_PLL: rd_val = {mode_lat_ff, regs_ff[1][5:0]};
      ckbsm_pkg::IDX_RSVD: rd_val = ckbsm_pkg::RSVD_READ;
      ckbsm_pkg::IDX_REV: rd_val = {REV_ID, VENDOR_ID};
      ckbsm_pkg::IDX_DEV: rd_val = {DEV_TYPE, DEV_ID};
      default: rd_val = 8'h00;
    endcase
  end

  // the count byte leads every read
  assign tx_val = first_rd_ff ? regs_ff[7] : rd_val;

  // bus protocol engine
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ckbsm_pkg::ST_IDLE;
      bit_cnt_ff <= 4'd0;
      sh_ff <= 8'h00;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= ckbsm_pkg::ST_ADDR;
      bit_cnt_ff <= 4'd0;
      sda_oe_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= ckbsm_pkg::ST_IDLE;
      sda_oe_ff <= 1'b0;
    end else begin
      case (state_ff)
        ckbsm_pkg::ST_ADDR, ckbsm_pkg::ST_RX: begin
          if (scl_rise && bit_cnt_ff != 4'd8) begin
            sh_ff <= {sh_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'd1;
          end
          if (addr_done) begin
            if (sh_ff[7:1] == ckbsm_pkg::SLV_ADDR) begin
              rw_ff <= sh_ff[0];
              state_ff <= ckbsm_pkg::ST_ACK;
              sda_oe_ff <= 1'b1;
            end else begin
              state_ff <= ckbsm_pkg::ST_IDLE;
            end
          end else if (rx_done) begin
            state_ff <= ckbsm_pkg::ST_ACK;
            sda_oe_ff <= 1'b1;
          end
        end
        ckbsm_pkg::ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= 4'd0;
            if (rw_ff) begin
              state_ff <= ckbsm_pkg::ST_TX;
              sh_ff <= tx_val;
              sda_oe_ff <= ~tx_val[7];
            end else begin
              state_ff <= ckbsm_pkg::ST_RX;
              sda_oe_ff <= 1'b0;
            end
          end
        end
        ckbsm_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_ff == 4'd7) begin
              state_ff <= ckbsm_pkg::ST_TACK;
              sda_oe_ff <= 1'b0;
            end else begin
              sh_ff <= {sh_ff[6:0], 1'b0};
              sda_oe_ff <= ~sh_ff[6];
              bit_cnt_ff <= bit_cnt_ff + 4'd1;
            end
          end
        end
        ckbsm_pkg::ST_TACK: begin
          if (scl_rise) begin
            nack_ff <= sda_s;
          end
          if (scl_fall) begin
            bit_cnt_ff <= 4'd0;
            if (nack_ff) begin
              state_ff <= ckbsm_pkg::ST_IDLE;
            end else begin
              state_ff <= ckbsm_pkg::ST_TX;
              sh_ff <= tx_val;
              sda_oe_ff <= ~tx_val[7];
            end
          end
        end
        default: state_ff <= ckbsm_pkg::ST_IDLE;
      endcase
    end
  end

  // byte sequencing: index, count, data; pointer walks on each data byte within the count and each read byte after the count
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_no_ff <= 2'd0;
      ptr_ff <= 8'h00;
      wcnt_ff <= 8'h00;
      first_rd_ff <= 1'b0;
    end else if (start_det) begin
      byte_no_ff <= 2'd0;
      first_rd_ff <= 1'b1;
    end else if (rx_done) begin
      if (byte_no_ff != 2'd2) begin
        byte_no_ff <= byte_no_ff + 2'd1;
      end
      if (byte_no_ff == 2'd0) begin
        ptr_ff <= sh_ff;
      end else if (byte_no_ff == 2'd1) begin
        wcnt_ff <= sh_ff;
      end else if (data_wr) begin
        wcnt_ff <= wcnt_ff - 8'h01;
        ptr_ff <= ptr_ff + 8'h01;
      end
    end else if (do_load) begin
      if (first_rd_ff) begin
        first_rd_ff <= 1'b0;
      end else begin
        ptr_ff <= ptr_ff + 8'h01;
      end
    end
  end

  // write strobe: bytes past the count are acknowledged but dropped
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_stb_ff <= 1'b0;
      wr_idx_ff <= 8'h00;
      wr_dat_ff <= 8'h00;
    end else begin
      wr_stb_ff <= data_wr;
      wr_idx_ff <= ptr_ff;
      wr_dat_ff <= sh_ff;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_ff;

  // controls to the analog side
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out0_run_o <= 1'b0;
      out1_run_o <= 1'b0;
      pll_mode_o <= 2'b00;
      amplitude_o <= ckbsm_pkg::RST_TAB[1][1:0];
      out0_edge_rate_sel_o <= ckbsm_pkg::RST_TAB[2][ckbsm_pkg::SLEW0_BIT];
      out1_edge_rate_sel_o <= ckbsm_pkg::RST_TAB[2][ckbsm_pkg::SLEW1_BIT];
      feedback_edge_rate_sel_o <= ckbsm_pkg::RST_TAB[3][ckbsm_pkg::FB_SLEW_BIT];
      freq_sw_en_o <= 1'b0;
      input_freq_sel_o <= ckbsm_pkg::FSEL_DEFAULT;
    end else begin
      out0_run_o <= regs_ff[0][ckbsm_pkg::OE0_BIT] & ~oe0_sy_ff[1];
      out1_run_o <= regs_ff[0][ckbsm_pkg::OE1_BIT] & ~oe1_sy_ff[1];
      pll_mode_o <= regs_ff[1][ckbsm_pkg::PLL_SW_BIT]
                    ? regs_ff[1][ckbsm_pkg::PLL_LO +: 2] : mode_lat_ff;
      amplitude_o <= regs_ff[1][1:0];
      out0_edge_rate_sel_o <= regs_ff[2][ckbsm_pkg::SLEW0_BIT];
      out1_edge_rate_sel_o <= regs_ff[2][ckbsm_pkg::SLEW1_BIT];
      feedback_edge_rate_sel_o <= regs_ff[3][ckbsm_pkg::FB_SLEW_BIT];
      freq_sw_en_o <= regs_ff[3][ckbsm_pkg::FSW_BIT];
      input_freq_sel_o <= regs_ff[3][ckbsm_pkg::FSW_BIT]
                          ? regs_ff[3][ckbsm_pkg::FSEL_LO +: 2] : ckbsm_pkg::FSEL_DEFAULT;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_addr_hit;
    addr_done ##0 (sh_ff[7:1] == ckbsm_pkg::SLV_ADDR);
  endsequence
  sequence s_addr_miss;
    addr_done ##0 (sh_ff[7:1] != ckbsm_pkg::SLV_ADDR);
  endsequence

  a_addr_ack_drive: assert property (s_addr_hit |=> sda_oe_o && state_ff == ckbsm_pkg::ST_ACK)
    else $error("no acknowledge for own address");
  a_addr_miss_quiet: assert property (s_addr_miss |=> !sda_oe_o [*2])
    else $error("drove bus for foreign address");
  a_oe_force_low: assert property (!regs_ff[0][ckbsm_pkg::OE0_BIT] |=> !out0_run_o)
    else $error("output 0 ran with enable bit clear");
  a_oe_pin_ctrl: assert property (regs_ff[0][ckbsm_pkg::OE1_BIT] && !oe1_sy_ff[1]
    |=> out1_run_o)
    else $error("output 1 stopped with bit and pin enabled");
  a_pll_mode_sel: assert property (1'b1 |=> pll_mode_o == ($past(regs_ff[1][5])
    ? $past(regs_ff[1][4:3]) : $past(mode_lat_ff)))
    else $error("pll mode source wrong");
  a_freq_gate: assert property (!regs_ff[3][ckbsm_pkg::FSW_BIT] |=> input_freq_sel_o == 2'b00)
    else $error("frequency select acted while disabled");
  a_amp_follow: assert property (1'b1 |=> amplitude_o == $past(regs_ff[1][1:0]))
    else $error("amplitude code does not follow register");
  a_rsvd_read: assert property (ptr_ff == ckbsm_pkg::IDX_RSVD && !first_rd_ff
    |-> tx_val == 8'hff)
    else $error("reserved register not all ones");
  a_count_upper: assert property (regs_ff[7][7:5] == 3'b000)
    else $error("byte count upper bits set");
  a_rsvd_keep: assert property ((regs_ff[0] & ~ckbsm_pkg::WMASK_TAB[0])
    == (ckbsm_pkg::RST_TAB[0] & ~ckbsm_pkg::WMASK_TAB[0]))
    else $error("reserved enable bits changed");
  a_write_lands: assert property (data_wr ##1 (wr_idx_ff == ckbsm_pkg::IDX_CNT)
    |=> regs_ff[7][4:0] == $past(wr_dat_ff[4:0]))
    else $error("count write lost");
  a_nack_ends: assert property ((state_ff == ckbsm_pkg::ST_TACK) && scl_fall && nack_ff
    && !start_det && !stop_det |=> state_ff == ckbsm_pkg::ST_IDLE && !sda_oe_o)
    else $error("transmit continued after not-acknowledge");
endmodule : ckbsm_regs

// ### verification/ckbsm_host_model.sv
// serial bus host model issuing indexed block transfers
`timescale 1ns/100ps
module ckbsm_host_model (
  // clock
  input wire logic mclk_i,
  // bus pins, sda_pull_o high pulls the open-drain line low
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  logic [7:0] tx_buf [9];
  logic [7:0] rx_buf [10];
  logic [7:0] nak_cnt;
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
    nak_cnt = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  // 800 ns bit; data moves late in the low phase so a slow ack release cannot race it
  task automatic bit_xfer(input logic b, output logic s);
    scl_o = 1'b0;
    tick(2);
    sda_pull_o = ~b;
    tick(3);
    scl_o = 1'b1;
    tick(2);
    s = sda_i;
    tick(1);
  endtask : bit_xfer
  // start and repeated start alike: sda falls while scl is high
  task automatic start_cond();
    scl_o = 1'b0;
    sda_pull_o = 1'b0;
    tick(6);
    scl_o = 1'b1;
    tick(4);
    sda_pull_o = 1'b1;
    tick(4);
  endtask : start_cond
  task automatic stop_cond();
    scl_o = 1'b0;
    tick(2);
    sda_pull_o = 1'b1;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    sda_pull_o = 1'b0;
    tick(8);
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    if (s !== 1'b0) nak_cnt++;
  endtask : send_byte
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(last, s);
  endtask : recv_byte
  task automatic write_block(input logic [7:0] adr, input logic [7:0] idx, input int cnt,
                             input int nsend);
    start_cond();
    send_byte(adr);
    send_byte(idx);
    send_byte(8'(cnt));
    for (int k = 0; k < nsend; k++) send_byte(tx_buf[k]);
    stop_cond();
  endtask : write_block
  task automatic read_block(input logic [7:0] idx, input int n);
    start_cond();
    send_byte(8'hda);
    send_byte(idx);
    start_cond();
    send_byte(8'hdb);
    recv_byte(1'b0, rx_buf[0]);
    for (int k = 1; k <= n; k++) recv_byte(k == n, rx_buf[k]);
    stop_cond();
  endtask : read_block
endmodule : ckbsm_host_model

// ### verification/test_clock_buffer_smbus_control_regs.sv
// self-checking bench of the clock buffer control register bank
`timescale 1ns/100ps
module test_clock_buffer_smbus_control_regs;
  localparam logic [3:0] T_REV = 4'h3; // arbitrary value
  localparam logic [3:0] T_VEN = 4'hc; // arbitrary value
  localparam logic [1:0] T_TYPE = 2'h2; // arbitrary value
  localparam logic [5:0] T_ID = 6'h15; // arbitrary value
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic oe0_n_i = 1'b0;
  logic oe1_n_i = 1'b0;
  logic [1:0] pll_mode_pin_i = 2'b10;
  logic scl, host_pull, sda_w, sda_o, sda_oe_o, out0_run_o, out1_run_o;
  logic [1:0] pll_mode_o, amplitude_o, input_freq_sel_o;
  logic out0_edge_rate_sel_o, out1_edge_rate_sel_o, feedback_edge_rate_sel_o, freq_sw_en_o;
  logic [7:0] mdl [8];
  int failures = 0;
  int cmp_count = 0;
  int seed = 56;
  // pull-up wins unless somebody pulls low
  assign sda_w = (host_pull || (sda_oe_o && !sda_o)) ? 1'b0 : 1'b1;
  always #50 mclk_i = ~mclk_i;
  ckbsm_regs #(.REV_ID(T_REV), .VENDOR_ID(T_VEN), .DEV_TYPE(T_TYPE), .DEV_ID(T_ID)) u_ckbsm_regs (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .oe0_n_i(oe0_n_i), .oe1_n_i(oe1_n_i), .pll_mode_pin_i(pll_mode_pin_i),
    .out0_run_o(out0_run_o), .out1_run_o(out1_run_o), .pll_mode_o(pll_mode_o),
    .amplitude_o(amplitude_o), .out0_edge_rate_sel_o(out0_edge_rate_sel_o),
    .out1_edge_rate_sel_o(out1_edge_rate_sel_o),
    .feedback_edge_rate_sel_o(feedback_edge_rate_sel_o), .freq_sw_en_o(freq_sw_en_o),
    .input_freq_sel_o(input_freq_sel_o));
  ckbsm_host_model u_ckbsm_host_model (
    .mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(host_pull));
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : wait_clk
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte
  // reserved bits keep their reset pattern, ids are fixed, pll bits latch the pins
  task automatic model_reset();
    for (int i = 0; i < 8; i++) mdl[i] = ckbsm_pkg::RST_TAB[i];
    mdl[1][7:6] = pll_mode_pin_i;
    mdl[5] = {T_REV, T_VEN};
    mdl[6] = {T_TYPE, T_ID};
  endtask : model_reset
  task automatic model_write(input int idx, input int cnt);
    for (int k = 0; k < cnt; k++) begin
      if (idx + k < 8) begin
        mdl[idx+k] = (mdl[idx+k] & ~ckbsm_pkg::WMASK_TAB[idx+k]) |
                     (u_ckbsm_host_model.tx_buf[k] & ckbsm_pkg::WMASK_TAB[idx+k]);
      end
    end
  endtask : model_write
  function automatic logic [7:0] exp_rd(input int i);
    return (i < 8) ? mdl[i] : 8'h00;
  endfunction : exp_rd
  task automatic read_check(input int idx, input int n);
    u_ckbsm_host_model.read_block(8'(idx), n);
    check_byte("count", mdl[7], u_ckbsm_host_model.rx_buf[0]);
    for (int k = 0; k < n; k++) begin
      check_byte($sformatf("reg%0d", idx + k), exp_rd(idx + k),
                 u_ckbsm_host_model.rx_buf[k+1]);
    end
  endtask : read_check
  task automatic check_outs();
    check_byte("out0_run", {7'h00, mdl[0][3] & ~oe0_n_i}, {7'h00, out0_run_o});
    check_byte("out1_run", {7'h00, mdl[0][5] & ~oe1_n_i}, {7'h00, out1_run_o});
    check_byte("pll_mode", {6'h00, mdl[1][5] ? mdl[1][4:3] : mdl[1][7:6]},
               {6'h00, pll_mode_o});
    check_byte("amplitude", {6'h00, mdl[1][1:0]}, {6'h00, amplitude_o});
    check_byte("edge_rates", {5'h00, mdl[2][5], mdl[2][3], mdl[3][0]},
               {5'h00, out1_edge_rate_sel_o, out0_edge_rate_sel_o,
                feedback_edge_rate_sel_o});
    check_byte("freq_sel", {5'h00, mdl[3][5], mdl[3][5] ? mdl[3][4:3] : 2'b00},
               {5'h00, freq_sw_en_o, input_freq_sel_o});
  endtask : check_outs
  task automatic do_reset();
    rst_n_i = 1'b0;
    pll_mode_pin_i = 2'($random(seed));
    wait_clk(3);
    rst_n_i = 1'b1;
    model_reset();
    wait_clk(10);
  endtask : do_reset
  initial begin
    #4000000;
    failures++;
    print_verdict();
  end
  initial begin
    do_reset();
    check_outs();
    read_check(0, 9);
    // all ones, all zeros, then random full writes; count field changes do not limit reads
    for (int it = 0; it < 5; it++) begin
      for (int k = 0; k < 8; k++) begin
        u_ckbsm_host_model.tx_buf[k] = (it == 0) ? 8'hff : (it == 1) ? 8'h00 : 8'($random(seed));
      end
      u_ckbsm_host_model.write_block(8'hda, 8'h00, 8, 8);
      model_write(0, 8);
      oe0_n_i = 1'($random(seed));
      oe1_n_i = 1'($random(seed));
      wait_clk(8);
      check_outs();
      read_check(0, 8);
    end
    // bytes past the written count are dropped
    u_ckbsm_host_model.tx_buf[0] = 8'($random(seed));
    u_ckbsm_host_model.tx_buf[1] = ~mdl[3];
    u_ckbsm_host_model.write_block(8'hda, 8'h02, 1, 2);
    model_write(2, 1);
    read_check(2, 2);
    check_byte("naks", 8'h00, u_ckbsm_host_model.nak_cnt);
    // foreign address gets no acknowledge and changes nothing
    u_ckbsm_host_model.tx_buf[0] = ~mdl[0];
    u_ckbsm_host_model.write_block(8'hd8, 8'h00, 1, 1);
    check_byte("naks", 8'h04, u_ckbsm_host_model.nak_cnt);
    read_check(0, 1);
    do_reset();
    check_outs();
    read_check(0, 8);
    print_verdict();
  end
endmodule : test_clock_buffer_smbus_control_regs
